// >>> pllcg_freq_check.sv
// Purpose: Checks reference, output and oscillator band for a setting
// Assumes: Reference frequency is given by software in whole MHz
// Notes:   Flags are advisory; they lag the setting by one cycle
`timescale 1ns/1ns
module pllcg_freq_check
  import pllcg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [MULT_W-1:0] mult_m1,
  input  wire logic [PDIV_W-1:0] pdiv_sel,
  input  wire logic [REF_W-1:0]  ref_mhz,
  output logic                   ref_ok_r,
  output logic                   out_ok_r,
  output logic                   osc_ok_r,
  output logic                   mul_ok_r
);

  function automatic logic in_band(input logic [FREQ_W-1:0] f,
                                   input logic [FREQ_W-1:0] lo,
                                   input logic [FREQ_W-1:0] hi);
    return (f >= lo) && (f <= hi);
  endfunction

  logic [FREQ_W-1:0] mult;
  logic [FREQ_W-1:0] out_mhz;
  logic [FREQ_W-1:0] osc_mhz;
  logic              ref_ok_nxt;
  logic              out_ok_nxt;
  logic              osc_ok_nxt;
  logic              mul_ok_nxt;

  always_comb begin
    mult       = FREQ_W'(mult_m1) + 1'b1;                  // [R4]
    out_mhz    = FREQ_W'(FREQ_W'(ref_mhz) * mult);         // [R3]
    // Output divide is 2 << sel, so the oscillator runs at that multiple
    // Sum widened first: two bits would wrap divide by 16 to no shift
    osc_mhz    = FREQ_W'(out_mhz << (3'(pdiv_sel) + 3'd1)); // [R5] [R6]
    ref_ok_nxt = in_band(FREQ_W'(ref_mhz), REF_MIN, REF_MAX);
    out_ok_nxt = in_band(out_mhz, OUT_MIN, OUT_MAX);
    osc_ok_nxt = in_band(osc_mhz, OSC_MIN, OSC_MAX);       // [R5]
    mul_ok_nxt = (mult <= MUL_CPU_MAX);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ok_r <= 1'b0;
      out_ok_r <= 1'b0;
      osc_ok_r <= 1'b0;
      mul_ok_r <= 1'b0;
    end else begin
      ref_ok_r <= ref_ok_nxt;
      out_ok_r <= out_ok_nxt;
      osc_ok_r <= osc_ok_nxt;
      mul_ok_r <= mul_ok_nxt;
    end
  end

endmodule // pllcg_freq_check

// >>> pllcg_lock_timer.sv
// Purpose: Counts settling time after the loop is enabled
// Assumes: enable and restart come from logic on pclk
// Notes:   Any restart or loss of enable drops lock at once
`timescale 1ns/1ns
module pllcg_lock_timer
  import pllcg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic restart,
  output logic      locked_r
);

  logic [LOCK_CNT_W-1:0] cnt_r;
  logic [LOCK_CNT_W-1:0] cnt_nxt;
  logic                  locked_nxt;

  always_comb begin
    cnt_nxt    = cnt_r;
    locked_nxt = locked_r;
    if (!enable || restart) begin
      cnt_nxt    = '0;
      locked_nxt = 1'b0;
    end else if (cnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
      locked_nxt = 1'b1; // [R10]
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= '0;
      locked_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      locked_r <= locked_nxt;
    end
  end

endmodule // pllcg_lock_timer

// >>> pllcg_pkg.sv
// Purpose: Shared constants for the processor clock loop controller
// Assumes: APB slave, 32-bit data, pclk at 10 MHz
// Notes:   Register offsets are byte addresses
package pllcg_pkg;

  localparam int unsigned CLK_MHZ       = 10;
  localparam int unsigned LOCK_TIME_US  = 100;
  localparam int unsigned LOCK_CYCLES   = LOCK_TIME_US * CLK_MHZ;
  localparam int unsigned LOCK_CNT_W    = 10;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_CFG       = 12'h004;
  localparam logic [11:0] OFS_STAT      = 12'h008;

  // Control fields
  localparam int unsigned CTRL_ENA_BIT  = 0;
  localparam int unsigned CTRL_CON_BIT  = 1;

  // Config fields
  localparam int unsigned CFG_MULT_LSB  = 0;
  localparam int unsigned MULT_W        = 5;
  localparam int unsigned CFG_PDIV_LSB  = 5;
  localparam int unsigned PDIV_W        = 2;
  localparam int unsigned CFG_REF_LSB   = 8;
  localparam int unsigned REF_W         = 5;

  // Status fields
  localparam int unsigned ST_LOCK_BIT   = 0;
  localparam int unsigned ST_CONN_BIT   = 1;
  localparam int unsigned ST_OSC_OK_BIT = 2;
  localparam int unsigned ST_OUT_OK_BIT = 3;
  localparam int unsigned ST_REF_OK_BIT = 4;
  localparam int unsigned ST_MUL_OK_BIT = 5;

  // Reset values
  localparam logic [MULT_W-1:0] MULT_RST = 5'h00;
  localparam logic [PDIV_W-1:0] PDIV_RST = 2'h0;
  localparam logic [REF_W-1:0]  REF_RST  = 5'h0a;

  // Frequency limits in MHz, and the software multiplier limit
  localparam int unsigned FREQ_W        = 14;
  localparam logic [FREQ_W-1:0] REF_MIN = 14'h000a;
  localparam logic [FREQ_W-1:0] REF_MAX = 14'h0019;
  localparam logic [FREQ_W-1:0] OUT_MIN = 14'h000a;
  localparam logic [FREQ_W-1:0] OUT_MAX = 14'h0046;
  localparam logic [FREQ_W-1:0] OSC_MIN = 14'h009c;
  localparam logic [FREQ_W-1:0] OSC_MAX = 14'h0140;
  localparam logic [FREQ_W-1:0] MUL_CPU_MAX = 14'h0006;

endpackage

// >>> pllcg_properties.sv
// Purpose: Port-level checks of the clock loop controller
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Settle time is judged by a counter of stable enabled cycles
`timescale 1ns/1ns
module pllcg_properties
  import pllcg_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready_r,
  input wire logic              pll_power_en_r,
  input wire logic              cpu_core_clock_sel_pll_r,
  input wire logic [MULT_W-1:0] pll_mult_m1_r,
  input wire logic [PDIV_W-1:0] pll_post_div_sel_r,
  input wire logic              pll_locked_r
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic [6:0]  cfg_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any change of multiplier or divider setting, or loss of enable, restarts settling
  always_comb begin
    cnt_nxt = cnt_r;
    if (!pll_power_en_r || {pll_mult_m1_r, pll_post_div_sel_r} != cfg_r) cnt_nxt = 11'h000;
    else if (cnt_r != 11'h7ff) cnt_nxt = cnt_r + 11'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 11'h000;
      cfg_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
      cfg_r <= {pll_mult_m1_r, pll_post_div_sel_r};
    end
  end
  property p_sel_lock; cpu_core_clock_sel_pll_r |-> pll_locked_r; endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("loop clock without lock");
  property p_en_drop; !pll_power_en_r |=> !pll_locked_r; endproperty
  a_en_drop: assert property (p_en_drop) else $error("lock while disabled");
  property p_early; $rose(pll_locked_r) |-> cnt_r >= 11'd998; endproperty
  a_early: assert property (p_early) else $error("lock came early");
  property p_in_time; cnt_r == 11'd1003 |-> pll_locked_r; endproperty
  a_in_time: assert property (p_in_time) else $error("lock came late");
  property p_cfg_drop; $changed({pll_mult_m1_r, pll_post_div_sel_r}) |=> !pll_locked_r; endproperty
  a_cfg_drop: assert property (p_cfg_drop) else $error("lock kept over new setting");
  property p_rdy; psel && !penable |=> pready_r; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_one; pready_r |=> !pready_r; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_rst; $rose(presetn) |-> !pll_power_en_r && !cpu_core_clock_sel_pll_r; endproperty
  a_rst: assert property (p_rst) else $error("loop active after reset");
endmodule // pllcg_properties

// >>> pllcg_sw_model.sv
// Purpose: Software side that programs the clock loop over APB
// Assumes: Slave may insert wait states; bench watchdog ends hangs
// Notes:   Write data is inverted once released
`timescale 1ns/1ns
module pllcg_sw_model
  import pllcg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata_r,
  input  wire logic        pready_r,
  input  wire logic        pslverr_r,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [11:0]      paddr = 12'h000,
  output logic [31:0]      pwdata = 32'h0
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_r !== 1'b1);
    q = prdata_r;
    e = pslverr_r;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
  // Reference and multiplier kept legal by the caller's setting
  task automatic bring_up(input logic [31:0] cfg, output int waited);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, OFS_CFG, cfg, q, e);
    xfer(1'b1, OFS_CTRL, 32'h1, q, e);
    waited = 0;
    do begin
      xfer(1'b0, OFS_STAT, 32'h0, q, e);
      waited += 3;
    end while (q[ST_LOCK_BIT] !== 1'b1);
    xfer(1'b1, OFS_CTRL, 32'h3, q, e);
  endtask
endmodule // pllcg_sw_model

// >>> pllcg_top.sv
// Purpose: APB controller for the processor clock loop and source select
// Assumes: Analog loop follows the enable, multiplier and divider outputs
// Notes:   Lock is modelled by a settling timer
// Notes on behaviour
// [R1] Processor clock is the oscillator unless loop is enabled, connected and locked.
// [R2] Software keeps the reference input between 10 and 25 MHz.
// [R3] Loop multiplies its input to an output of 10 to 70 MHz.
// [R4] Multiplier 1 to 32 supported; software stays at 6 or below.
// [R5] Loop divider keeps the oscillator between 156 and 320 MHz.
// [R6] Output divider selects divide by 2, 4, 8 or 16.
// [R7] Divide of at least two gives a 50 percent duty cycle output.
// [R8] After reset the loop is disabled and bypassed until software acts.
// [R9] Software configures, enables, waits for lock, then connects.
// [R10] Lock is reached within 100 microseconds of enabling.
// [R11] Lock indication is readable by software.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module pllcg_top
  import pllcg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata_r,
  output logic                   pready_r,
  output logic                   pslverr_r,
  output logic                   pll_power_en_r,
  output logic                   cpu_core_clock_sel_pll_r,
  output logic      [MULT_W-1:0] pll_mult_m1_r,
  output logic      [PDIV_W-1:0] pll_post_div_sel_r,
  output logic                   pll_locked_r
);

  logic              ena_r;
  logic              ena_nxt;
  logic              con_r;
  logic              con_nxt;
  logic [MULT_W-1:0] mult_r;
  logic [MULT_W-1:0] mult_nxt;
  logic [PDIV_W-1:0] pdiv_r;
  logic [PDIV_W-1:0] pdiv_nxt;
  logic [REF_W-1:0]  ref_r;
  logic [REF_W-1:0]  ref_nxt;
  logic [31:0]       prdata_nxt;
  logic              pready_nxt;
  logic              pslverr_nxt;
  logic              sel_pll_nxt;
  logic              restart;
  logic              locked;
  logic              ref_ok;
  logic              out_ok;
  logic              osc_ok;
  logic              mul_ok;
  logic              wr_en;
  logic              mapped;
  logic [31:0]       rd_word;

  // Bus slave: one access cycle, pready raised from setup
  always_comb begin
    wr_en   = psel && penable && pready_r && pwrite;
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == OFS_CTRL) begin
      rd_word[CTRL_ENA_BIT] = ena_r;
      rd_word[CTRL_CON_BIT] = con_r;
    end else if (paddr == OFS_CFG) begin
      rd_word[CFG_MULT_LSB +: MULT_W] = mult_r;
      rd_word[CFG_PDIV_LSB +: PDIV_W] = pdiv_r;
      rd_word[CFG_REF_LSB  +: REF_W]  = ref_r;
    end else if (paddr == OFS_STAT) begin
      rd_word[ST_LOCK_BIT]   = locked;                    // [R11]
      rd_word[ST_CONN_BIT]   = cpu_core_clock_sel_pll_r;
      rd_word[ST_OSC_OK_BIT] = osc_ok;
      rd_word[ST_OUT_OK_BIT] = out_ok;
      rd_word[ST_REF_OK_BIT] = ref_ok;
      rd_word[ST_MUL_OK_BIT] = mul_ok;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    pready_nxt  = psel && !penable && !pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      prdata_nxt  = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_nxt = !mapped;
    end
  end

  // Register file
  always_comb begin
    ena_nxt  = ena_r;
    con_nxt  = con_r;
    mult_nxt = mult_r;
    pdiv_nxt = pdiv_r;
    ref_nxt  = ref_r;
    restart  = 1'b0;
    if (wr_en && paddr == OFS_CTRL) begin
      ena_nxt = pwdata[CTRL_ENA_BIT];
      con_nxt = pwdata[CTRL_CON_BIT];
    end
    if (wr_en && paddr == OFS_CFG) begin
      mult_nxt = pwdata[CFG_MULT_LSB +: MULT_W];          // [R4]
      // Two-bit field cannot encode a divide below two
      pdiv_nxt = pwdata[CFG_PDIV_LSB +: PDIV_W];          // [R6] [R7]
      ref_nxt  = pwdata[CFG_REF_LSB +: REF_W];
      // New setting must settle again before use
      restart  = 1'b1;                                    // [R10]
    end
  end

  // Source select follows lock, so losing lock falls back at once
  always_comb begin
    sel_pll_nxt = ena_r && con_r && locked;               // [R1]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r                 <= 32'h0000_0000;
      pready_r                 <= 1'b0;
      pslverr_r                <= 1'b0;
      ena_r                    <= 1'b0;                   // [R8]
      con_r                    <= 1'b0;                   // [R8]
      mult_r                   <= MULT_RST;
      pdiv_r                   <= PDIV_RST;
      ref_r                    <= REF_RST;
      pll_power_en_r           <= 1'b0;
      cpu_core_clock_sel_pll_r <= 1'b0;
      pll_mult_m1_r            <= MULT_RST;
      pll_post_div_sel_r       <= PDIV_RST;
      pll_locked_r             <= 1'b0;
    end else begin
      prdata_r                 <= prdata_nxt;
      pready_r                 <= pready_nxt;
      pslverr_r                <= pslverr_nxt;
      ena_r                    <= ena_nxt;
      con_r                    <= con_nxt;
      mult_r                   <= mult_nxt;
      pdiv_r                   <= pdiv_nxt;
      ref_r                    <= ref_nxt;
      pll_power_en_r           <= ena_r;
      cpu_core_clock_sel_pll_r <= sel_pll_nxt;
      pll_mult_m1_r            <= mult_r;
      pll_post_div_sel_r       <= pdiv_r;
      pll_locked_r             <= locked;
    end
  end

  pllcg_lock_timer u_lock (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (ena_r),
    .restart  (restart),
    .locked_r (locked)
  );

  pllcg_freq_check u_chk (
    .pclk     (pclk),
    .presetn  (presetn),
    .mult_m1  (mult_r),
    .pdiv_sel (pdiv_r),
    .ref_mhz  (ref_r),
    .ref_ok_r (ref_ok),
    .out_ok_r (out_ok),
    .osc_ok_r (osc_ok),
    .mul_ok_r (mul_ok)
  );

endmodule // pllcg_top

// >>> tb.sv
// Purpose: Self-checking bench for the clock loop controller
// Assumes: pclk 10 MHz, reset held 8 cycles
// Notes:   Bus cycles come from the software model
`timescale 1ns/1ns
module tb;
  import pllcg_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel, penable, pwrite, pready_r, pslverr_r, en, sel, lk, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata_r, q;
  logic [MULT_W-1:0] mult;
  logic [PDIV_W-1:0] pdiv;
  int                failures = 0, n_compared = 0, cyc = 0, w;
  int                tm[5] = '{3, 32, 2, 1, 6};
  int                ts[5] = '{2, 3, 0, 0, 1};
  int                tr[5] = '{13, 10, 25, 9, 10};
  pllcg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .pll_power_en_r(en),
    .cpu_core_clock_sel_pll_r(sel), .pll_mult_m1_r(mult), .pll_post_div_sel_r(pdiv),
    .pll_locked_r(lk));
  pllcg_sw_model u_sw (.pclk(pclk), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial forever #50 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    u_sw.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_sw.xfer(1'b1, a, d, q, e);
  endtask
  function automatic logic [31:0] st(int m, int s, int r, logic lc);
    int o = r * m;
    int c = o * (2 << s);
    st = {26'h0, m <= 6, r >= 10 && r <= 25, o >= 10 && o <= 70, c >= 156 && c <= 320, lc, lc};
  endfunction
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    chk("outputs", 32'h0, {22'h0, en, sel, lk, mult, pdiv});
    presetn <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl", 32'h0, q);
    rd(OFS_CFG);
    chk("cfg", 32'h0a00, q);
    rd(12'h00c);
    chk("unmapped", 32'h1, {q[30:0], e});
    wr(OFS_STAT, 32'hffffffff);
    chk("stat_wr_err", 32'h0, {31'h0, e});
    rd(OFS_STAT);
    chk("stat", st(1, 0, 10, 1'b0), q);
    foreach (tm[i]) begin
      wr(OFS_CFG, {19'h0, 5'(tr[i]), 1'b0, 2'(ts[i]), 5'(tm[i] - 1)});
      rd(OFS_STAT);
      chk("band", st(tm[i], ts[i], tr[i], 1'b0), q);
      chk("mult", 32'(tm[i] - 1), {27'h0, mult});
      chk("pdiv", 32'(ts[i]), {30'h0, pdiv});
    end
    wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    chk("sel_noen", 32'h0, {31'h0, sel});
    u_sw.bring_up(32'h0a25, w);
    chk("lock_wait", 32'h1, {31'h0, w >= 996 && w <= 1008});
    repeat (3) @(posedge pclk);
    chk("sel_on", 32'h7, {29'h0, en, sel, lk});
    rd(OFS_STAT);
    chk("stat_on", st(6, 1, 10, 1'b1), q);
    wr(OFS_CFG, 32'h0a24);
    repeat (3) @(posedge pclk);
    chk("sel_cfg", 32'h4, {29'h0, en, sel, lk});
    repeat (1005) @(posedge pclk);
    chk("relock", 32'h7, {29'h0, en, sel, lk});
    wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    chk("sel_off", 32'h0, {29'h0, en, sel, lk});
    // Reset lands on the enabling edge, so enable must never show
    wr(OFS_CTRL, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst_mid", 32'h0, {22'h0, en, sel, lk, mult, pdiv});
    presetn <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl_rst", 32'h0, q);
    rd(OFS_CFG);
    chk("cfg_rst", 32'h0a00, q);
    final_report;
  end
endmodule // tb
bind pllcg_top pllcg_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready_r(pready_r), .pll_power_en_r(pll_power_en_r),
  .cpu_core_clock_sel_pll_r(cpu_core_clock_sel_pll_r), .pll_mult_m1_r(pll_mult_m1_r),
  .pll_post_div_sel_r(pll_post_div_sel_r), .pll_locked_r(pll_locked_r));
